// [vsc_syscon_irq.sv]
// backplane system controller, requester, mailboxes and interrupt handler
//
// Summary of operation
// - transfer mode register selects A32/A24, D32/D16/D8 eo, BLT32 and MBLT64
// - system controller functions run only when the slot-one enable is set
// - arbiter grants by rotating, single level or fixed priority mode
// - as controller: drive sysclk, iack daisy chain, time out long accesses
// - grant without busy within 16 or 256 us raises arbitration timeout
// - requester drives the software-selected request level of four
// - bus release on other request, after transfer, or capture and hold
// - four 32-bit mailboxes writable and readable from both sides
// - backplane mailbox access sets a status event
// - each backplane interrupt line has its own handler enable
// - mailbox and line events map to INTA# or SERR#; the own-ack event is never raised
// - ACFAIL, BERR and SYSFAIL events map to INTA# or SERR#
// - SERR# assertion also raises the host non-maskable interrupt
// - one vector register per interrupt level
// - handler first owns the bus, then runs acknowledge at that level
// - vector stored and status bit set on the same edge, then mapped interrupt raised
// - interrupt levels seven down to one are handled
//
// The AHB-Lite register port and the register addresses were decided locally.
`include "vsc_consts.svh"
`default_nettype none
module vsc_syscon_irq #(
  parameter int SYSCLK_DIV = 1,
  parameter int ACC_TO_US  = `VSC_ACC_TO_US
) (
  // clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // register bus
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic [31:0]              hrdata,
  output logic                     hresp,
  // host interrupts
  output logic                     irq,
  output logic                     inta_n,
  output logic                     serr_n,
  output logic                     nmi,
  // backplane pins in, active low unless noted
  input  wire logic [3:0]          br_in_n,
  input  wire logic [3:0]          bg_in_n,
  input  wire logic                bbsy_in_n,
  input  wire logic [7:1]          irq_in_n,
  input  wire logic                acfail_n,
  input  wire logic                berr_in_n,
  input  wire logic                sysfail_n,
  input  wire logic                iack_in_n,
  input  wire logic                ds_in_n,
  input  wire logic                dtack_in_n,
  input  wire logic [7:0]          vec_in,
  // backplane pins out, open drain enables pull low
  output logic [3:0]               br_oe,
  output logic                     bbsy_oe,
  output logic                     berr_oe,
  output logic                     iack_oe,
  output logic [2:0]               iack_lvl,
  output logic [3:0]               bg_out_n,
  output logic                     iackout_n,
  output logic                     sysclk_o,
  output logic                     sysclk_oe,
  output vsc_pkg::vsc_xfer_t       xfer_cfg,
  // backplane side mailbox port
  input  wire logic                mbx_acc,
  input  wire logic                mbx_wr,
  input  wire logic [1:0]          mbx_idx,
  input  wire logic [31:0]         mbx_wdata,
  output logic [31:0]              mbx_rdata
);
  localparam int ARB_SHORT_CYC = `VSC_ARB_SHORT_US * `VSC_CLK_MHZ;
  localparam int ARB_LONG_CYC  = `VSC_ARB_LONG_US * `VSC_CLK_MHZ;
  localparam int ACC_CYC       = ACC_TO_US * `VSC_CLK_MHZ;
  localparam int NP            = 30;

  if (SYSCLK_DIV < 1 || SYSCLK_DIV > 255 || ACC_CYC < 2 || ACC_CYC > 65535) begin : g_bad_param
    $error("vsc_syscon_irq: parameter out of range");
  end

  // pin synchronisers
  logic [NP-1:0] pin_raw;
  logic [NP-1:0] p1;
  logic [NP-1:0] p2;
  logic [NP-1:0] p3;
  logic [NP-1:0] pin_s;
  logic [3:0]    br_s;
  logic [3:0]    bg_s;
  logic          bbsy_s;
  logic [6:0]    irq_s;
  logic          acfail_s;
  logic          berr_s;
  logic          sysfail_s;
  logic          iack_s;
  logic          ds_s;
  logic          dtack_s;
  logic [7:0]    vec_s;

  assign pin_raw = {br_in_n, bg_in_n, bbsy_in_n, irq_in_n, acfail_n, berr_in_n, sysfail_n,
                    iack_in_n, ds_in_n, dtack_in_n, vec_in};

  for (genvar gi = 0; gi < NP; gi++) begin : g_sync
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        p1[gi]    <= 1'b1;
        p2[gi]    <= 1'b1;
        p3[gi]    <= 1'b1;
        pin_s[gi] <= 1'b1;
      end else begin
        p1[gi] <= pin_raw[gi];
        p2[gi] <= p1[gi];
        p3[gi] <= p2[gi];
        if (p2[gi] == p3[gi]) begin
          pin_s[gi] <= p3[gi];
        end
      end
    end
  end

  assign {br_s, bg_s, bbsy_s, irq_s, acfail_s, berr_s, sysfail_s, iack_s, ds_s, dtack_s, vec_s} = pin_s;

  // register state
  vsc_pkg::vsc_ctrl_t     ctrl;
  vsc_pkg::vsc_xfer_t     xfer;
  logic [`VSC_NEV-1:0]    status;
  logic [`VSC_NEV-1:0]    ien;
  logic [`VSC_NEV-1:0]    imap;
  logic [`VSC_NEV-1:0]    ev;
  logic [`VSC_NEV-1:0]    clr;
  logic [6:0]             hen;
  logic [31:0]            mbx [4];
  logic [7:0]             vec [7];
  logic                   ap_wr;
  logic [7:0]             ap_addr;
  logic                   wen;
  logic [31:0]            rd_data;
  vsc_pkg::vsc_hs_t       hs;
  vsc_pkg::vsc_as_t       arb;
  vsc_pkg::vsc_rq_t       rq;
  logic [2:0]             hlvl;
  logic [6:0]             pend;
  logic                   hdl_need;
  logic                   need;
  logic [1:0]             glvl;
  logic [1:0]             last_lvl;
  logic [11:0]            arb_cnt;
  logic [11:0]            arb_lim;
  logic [15:0]            acc_cnt;
  logic [7:0]             div_cnt;
  logic                   acfail_q;
  logic                   berr_q;
  logic                   sysfail_q;

  // bus slave: zero wait state, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wen       = ap_wr;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr   <= 1'b0;
      ap_addr <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end else begin
      ap_wr   <= hsel && htrans[1] && hready && hwrite;
      ap_addr <= haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite) begin
        hrdata <= rd_data;
      end
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    case (haddr[7:0])
      `VSC_OFF_CTRL:  rd_data = ctrl;
      `VSC_OFF_STAT:  rd_data = {15'h0000, status};
      `VSC_OFF_IEN:   rd_data = {15'h0000, ien};
      `VSC_OFF_IMAP:  rd_data = {15'h0000, imap};
      `VSC_OFF_HEN:   rd_data = {24'h00_0000, hen, 1'b0};
      `VSC_OFF_XFER:  rd_data = xfer;
      `VSC_OFF_BSTAT: rd_data = {19'h0_0000, hlvl, rq, arb, hs};
      default: begin
        for (int i = 0; i < 4; i++) begin
          if (haddr[7:0] == `VSC_OFF_MBX + 8'(4 * i)) begin
            rd_data = mbx[i];
          end
        end
        for (int i = 0; i < 7; i++) begin
          if (haddr[7:0] == `VSC_OFF_VEC + 8'(4 * i)) begin
            rd_data = {24'h00_0000, vec[i]};
          end
        end
      end
    endcase
  end

  // configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= vsc_pkg::vsc_ctrl_t'(`VSC_CTRL_RST);
      xfer <= vsc_pkg::vsc_xfer_t'(`VSC_XFER_RST);
      ien  <= `VSC_IEN_RST;
      imap <= `VSC_IMAP_RST;
      hen  <= `VSC_HEN_RST;
    end else if (wen) begin
      case (ap_addr)
        `VSC_OFF_CTRL: ctrl <= vsc_pkg::vsc_ctrl_t'({22'h00_0000, hwdata[9:0]});
        `VSC_OFF_XFER: xfer <= vsc_pkg::vsc_xfer_t'({27'h000_0000, hwdata[4:0]});
        `VSC_OFF_IEN:  ien  <= hwdata[`VSC_NEV-1:0];
        `VSC_OFF_IMAP: imap <= hwdata[`VSC_NEV-1:0];
        `VSC_OFF_HEN:  hen  <= hwdata[7:1];
        default: ;
      endcase
    end
  end

  assign xfer_cfg = xfer;

  // sticky status: an event in the clearing cycle survives
  assign clr = (wen && ap_addr == `VSC_OFF_ICLR) ? hwdata[`VSC_NEV-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= '0;
    end else begin
      status <= (status & ~clr) | ev;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acfail_q  <= 1'b1;
      berr_q    <= 1'b1;
      sysfail_q <= 1'b1;
    end else begin
      acfail_q  <= acfail_s;
      berr_q    <= berr_s;
      sysfail_q <= sysfail_s;
    end
  end

  assign ev[`VSC_ST_OWNACK]  = iack_s == 1'b0 && ev_unused_guard();
  assign ev[`VSC_ST_ACFAIL]  = acfail_q && !acfail_s;
  assign ev[`VSC_ST_BERR]    = berr_q && !berr_s;
  assign ev[`VSC_ST_SYSFAIL] = sysfail_q && !sysfail_s;

  function automatic logic ev_unused_guard();
    return 1'b0;
  endfunction

  // host interrupt lines, mapped per bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq    <= 1'b0;
      inta_n <= 1'b1;
      serr_n <= 1'b1;
      nmi    <= 1'b0;
    end else begin
      irq    <= |(status & ien);
      inta_n <= ~|(status & ien & ~imap);
      serr_n <= ~|(status & ien & imap);
      nmi    <= |(status & ien & imap);
    end
  end

  // mailboxes: backplane write wins a same-cycle collision
  for (genvar gm = 0; gm < 4; gm++) begin : g_mbx
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        mbx[gm] <= 32'h0000_0000;
      end else if (mbx_acc && mbx_wr && mbx_idx == 2'(gm)) begin
        mbx[gm] <= mbx_wdata;
      end else if (wen && ap_addr == `VSC_OFF_MBX + 8'(4 * gm)) begin
        mbx[gm] <= hwdata;
      end
    end
    assign ev[`VSC_ST_MBX + gm] = mbx_acc && mbx_idx == 2'(gm);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mbx_rdata <= 32'h0000_0000;
    end else if (mbx_acc && !mbx_wr) begin
      mbx_rdata <= mbx[mbx_idx];
    end
  end

  // interrupt handler
  function automatic logic [2:0] pick_irq(input logic [6:0] p);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 7; i++) begin
      if (p[i]) begin
        r = 3'(i + 1);
      end
    end
    return r;
  endfunction

  assign pend     = ~irq_s & hen & ~status[`VSC_ST_IRQ +: 7];
  assign hdl_need = hs != vsc_pkg::hs_idle;
  assign iack_oe  = hs == vsc_pkg::hs_iack;
  assign iack_lvl = hlvl;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs   <= vsc_pkg::hs_idle;
      hlvl <= 3'h0;
    end else begin
      case (hs)
        vsc_pkg::hs_idle: begin
          if (|pend) begin
            hlvl <= pick_irq(pend);
            hs   <= vsc_pkg::hs_req;
          end
        end
        vsc_pkg::hs_req: begin
          if (!pend[hlvl - 3'h1]) begin
            hs <= vsc_pkg::hs_idle;
          end else if (rq == vsc_pkg::rq_own) begin
            hs <= vsc_pkg::hs_iack;
          end
        end
        vsc_pkg::hs_iack: begin
          if (!dtack_s || !berr_s) begin
            hs <= vsc_pkg::hs_done;
          end
        end
        vsc_pkg::hs_done: begin
          if (dtack_s && berr_s) begin
            hs <= vsc_pkg::hs_idle;
          end
        end
        default: hs <= vsc_pkg::hs_idle;
      endcase
    end
  end

  for (genvar gv = 0; gv < 7; gv++) begin : g_vec
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        vec[gv] <= 8'h00;
      end else if (ev[`VSC_ST_IRQ + gv]) begin
        vec[gv] <= vec_s;
      end
    end
    assign ev[`VSC_ST_IRQ + gv] = hs == vsc_pkg::hs_iack && !dtack_s && hlvl == 3'(gv + 1);
  end

  // requester
  assign need = ctrl.req || hdl_need;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rq <= vsc_pkg::rq_idle;
    end else begin
      case (rq)
        vsc_pkg::rq_idle: begin
          if (need) begin
            rq <= vsc_pkg::rq_wait;
          end
        end
        vsc_pkg::rq_wait: begin
          if (!bg_s[ctrl.req_lvl] && bbsy_s) begin
            rq <= vsc_pkg::rq_own;
          end
        end
        vsc_pkg::rq_own: begin
          case (ctrl.rel_mode)
            vsc_pkg::release_on_other_request: if (!need && !(&br_s)) rq <= vsc_pkg::rq_idle;
            vsc_pkg::release_after_transfer:   if (!need) rq <= vsc_pkg::rq_idle;
            default:                           if (!need && !ctrl.hold) rq <= vsc_pkg::rq_idle;
          endcase
        end
        default: rq <= vsc_pkg::rq_idle;
      endcase
    end
  end

  assign br_oe   = (rq == vsc_pkg::rq_wait) ? 4'h1 << ctrl.req_lvl : 4'h0;
  assign bbsy_oe = rq == vsc_pkg::rq_own;

  // arbiter, active only as system controller
  function automatic logic [1:0] pick_br(input logic [3:0] r, input logic [1:0] top);
    logic [1:0] idx;
    logic [1:0] res;
    res = top;
    for (int k = 0; k < 4; k++) begin
      idx = 2'(top + 2'(k) + 2'h1);
      if (r[idx]) begin
        res = idx;
      end
    end
    return res;
  endfunction

  assign arb_lim = ctrl.arb_long ? 12'(ARB_LONG_CYC) : 12'(ARB_SHORT_CYC);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arb      <= vsc_pkg::as_idle;
      glvl     <= 2'h0;
      last_lvl <= 2'h0;
      arb_cnt  <= 12'h000;
    end else if (!ctrl.syscon_en) begin
      arb     <= vsc_pkg::as_idle;
      arb_cnt <= 12'h000;
    end else begin
      case (arb)
        vsc_pkg::as_idle: begin
          arb_cnt <= 12'h000;
          if (bbsy_s && ctrl.arb_mode == vsc_pkg::single_level_arbitration) begin
            if (!br_s[3]) begin
              glvl <= 2'h3;
              arb  <= vsc_pkg::as_grant;
            end
          end else if (bbsy_s && !(&br_s)) begin
            glvl <= (ctrl.arb_mode == vsc_pkg::rotating_arbitration) ?
                    pick_br(~br_s, 2'(last_lvl - 2'h1)) : pick_br(~br_s, 2'h3);
            arb  <= vsc_pkg::as_grant;
          end
        end
        vsc_pkg::as_grant: begin
          arb_cnt <= arb_cnt + 12'h001;
          if (!bbsy_s) begin
            last_lvl <= glvl;
            arb      <= vsc_pkg::as_busy;
          end else if (arb_cnt == arb_lim - 12'h001) begin
            arb <= vsc_pkg::as_idle;
          end
        end
        vsc_pkg::as_busy: begin
          if (bbsy_s) begin
            arb <= vsc_pkg::as_idle;
          end
        end
        default: arb <= vsc_pkg::as_idle;
      endcase
    end
  end

  assign ev[`VSC_ST_ARBTO] = arb == vsc_pkg::as_grant && bbsy_s && arb_cnt == arb_lim - 12'h001;
  assign bg_out_n          = (arb == vsc_pkg::as_grant) ? ~(4'h1 << glvl) : 4'hf;

  // access timeout, sysclk and iack daisy chain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_cnt <= 16'h0000;
      berr_oe <= 1'b0;
    end else if (!ctrl.syscon_en || ds_s) begin
      acc_cnt <= 16'h0000;
      berr_oe <= 1'b0;
    end else if (acc_cnt == 16'(ACC_CYC - 1)) begin
      berr_oe <= 1'b1;
    end else begin
      acc_cnt <= acc_cnt + 16'h0001;
    end
  end

  assign ev[`VSC_ST_ACCTO] = ctrl.syscon_en && !ds_s && !berr_oe && acc_cnt == 16'(ACC_CYC - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt   <= 8'h00;
      sysclk_o  <= 1'b0;
      sysclk_oe <= 1'b0;
      iackout_n <= 1'b1;
    end else begin
      sysclk_oe <= ctrl.syscon_en;
      iackout_n <= ctrl.syscon_en ? iack_s : 1'b1;
      if (div_cnt == 8'(SYSCLK_DIV - 1)) begin
        div_cnt  <= 8'h00;
        sysclk_o <= ctrl.syscon_en && !sysclk_o;
      end else begin
        div_cnt <= div_cnt + 8'h01;
      end
    end
  end

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_set_wins_clear: assert property (ev[`VSC_ST_MBX] && clr[`VSC_ST_MBX] |=> status[`VSC_ST_MBX])
    else $error("event lost in clearing cycle");
  a_inta_mapped: assert property (|(status & ien & ~imap) |=> !inta_n)
    else $error("inta not raised for mapped status");
  a_nmi_with_serr: assert property (nmi == !serr_n)
    else $error("nmi does not follow serr");
  a_vector_stored: assert property (hs == vsc_pkg::hs_iack && !dtack_s && hlvl == 3'h7
                                    |=> status[6] && vec[6] == $past(vec_s))
    else $error("vector or status not stored after acknowledge");
  a_iack_owns_bus: assert property (iack_oe |-> rq == vsc_pkg::rq_own && bbsy_oe)
    else $error("acknowledge without bus ownership");
  a_arb_timeout: assert property (arb == vsc_pkg::as_grant && bbsy_s && arb_cnt == arb_lim - 12'h001
                                  |=> arb == vsc_pkg::as_idle && status[`VSC_ST_ARBTO])
    else $error("arbitration timeout not flagged");
  a_br_level: assert property (rq == vsc_pkg::rq_wait |-> br_oe == 4'h1 << ctrl.req_lvl && $onehot(br_oe))
    else $error("request on wrong level");
  a_vector_kept: assert property (status[6] && $past(status[6]) |-> $stable(vec[6]))
    else $error("vector overwritten while status set");
  a_syscon_off: assert property (!ctrl.syscon_en |=> bg_out_n == 4'hf && !sysclk_oe)
    else $error("controller outputs active while disabled");
  a_rwd_release: assert property (rq == vsc_pkg::rq_own && ctrl.rel_mode == vsc_pkg::release_after_transfer
                                  && !need |=> rq == vsc_pkg::rq_idle ##1 !bbsy_oe)
    else $error("bus not released after transfer");
endmodule
`default_nettype wire

// [vsc_consts.svh]
// register offsets, status bit positions, reset values and timing figures
`ifndef VSC_CONSTS_SVH
`define VSC_CONSTS_SVH

// register byte offsets
`define VSC_OFF_CTRL   8'h00
`define VSC_OFF_STAT   8'h04
`define VSC_OFF_IEN    8'h08
`define VSC_OFF_ICLR   8'h0c
`define VSC_OFF_IMAP   8'h10
`define VSC_OFF_HEN    8'h14
`define VSC_OFF_XFER   8'h18
`define VSC_OFF_BSTAT  8'h1c
`define VSC_OFF_MBX    8'h20
`define VSC_OFF_VEC    8'h40

// status, enable, clear and map bit positions
`define VSC_NEV        17
`define VSC_ST_IRQ     0
`define VSC_ST_MBX     7
`define VSC_ST_OWNACK  11
`define VSC_ST_ACFAIL  12
`define VSC_ST_BERR    13
`define VSC_ST_SYSFAIL 14
`define VSC_ST_ARBTO   15
`define VSC_ST_ACCTO   16

// reset values
`define VSC_CTRL_RST   32'h0000_0000
`define VSC_XFER_RST   32'h0000_0001
`define VSC_IEN_RST    17'h0_0000
`define VSC_IMAP_RST   17'h0_0000
`define VSC_HEN_RST    7'h00

// timing
`define VSC_CLK_MHZ        10
`define VSC_ARB_SHORT_US   16
`define VSC_ARB_LONG_US    256
`define VSC_ACC_TO_US      64

`endif

// [vsc_pkg.sv]
// types shared by the backplane control block
`default_nettype none
package vsc_pkg;
  typedef enum logic [1:0] {
    rotating_arbitration       = 2'h0,
    single_level_arbitration   = 2'h1,
    fixed_priority_arbitration = 2'h2
  } vsc_arb_mode_t;
  typedef enum logic [1:0] {
    release_on_other_request = 2'h0,
    release_after_transfer   = 2'h1,
    bus_capture_hold         = 2'h2
  } vsc_rel_mode_t;
  typedef enum logic [3:0] {hs_idle = 4'h1, hs_req = 4'h2, hs_iack = 4'h4, hs_done = 4'h8} vsc_hs_t;
  typedef enum logic [2:0] {as_idle = 3'h1, as_grant = 3'h2, as_busy = 3'h4} vsc_as_t;
  typedef enum logic [2:0] {rq_idle = 3'h1, rq_wait = 3'h2, rq_own = 3'h4} vsc_rq_t;
  typedef struct packed {
    logic [21:0]   pad;
    logic          hold;
    logic          req;
    vsc_rel_mode_t rel_mode;
    logic [1:0]    req_lvl;
    logic          arb_long;
    vsc_arb_mode_t arb_mode;
    logic          syscon_en;
  } vsc_ctrl_t;
  typedef struct packed {
    logic [26:0] pad;
    logic        mblt64;
    logic        blt32;
    logic [1:0]  dsize;
    logic        a32;
  } vsc_xfer_t;
endpackage
`default_nettype wire

// [vsc_bp_model.sv]
// backplane partner model: bus grant and interrupt acknowledge responder
`default_nettype none
module vsc_bp_model #(
  parameter int DLY = 5
) (
  // from the device
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [3:0] br_oe,
  input  wire logic       iack_oe,
  input  wire logic [2:0] iack_lvl,
  // backplane answers
  output logic [3:0]      bg_in_n,
  output logic            dtack_in_n,
  output logic [7:0]      vec_in
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bg_in_n    <= 4'hf;
      dtack_in_n <= 1'b1;
      vec_in     <= 8'h00;
      cnt        <= 0;
    end else begin
      bg_in_n <= ~br_oe;
      cnt <= iack_oe ? cnt + 1 : 0;
      if (iack_oe && cnt == 1)
        vec_in <= 8'ha0 | {5'h00, iack_lvl};
      if (iack_oe && cnt == DLY)
        dtack_in_n <= 1'b0;
      else if (!iack_oe) begin
        // released vector lines wander
        dtack_in_n <= 1'b1;
        vec_in <= ~vec_in;
      end
    end
  end
endmodule
`default_nettype wire

// [tb_vsc_syscon_irq.sv]
// self-checking bench for the backplane control block
`include "vsc_consts.svh"
`default_nettype none
module tb_vsc_syscon_irq;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, mbx_acc = 0, mbx_wr = 0;
  logic [31:0] haddr = 0, hwdata = 0, mbx_wdata = 0, rd, d, m, seed = 32'h44;
  logic [1:0] htrans = 0, mbx_idx = 0;
  logic [7:1] irq_in_n = 7'h7f;
  logic [2:0] err_n = 3'h7, iack_lvl;
  logic hreadyout, irq, inta_n, serr_n, nmi, bbsy_oe, berr_oe, iack_oe, sysclk_oe, dtack_in_n;
  logic iackout_n, sysclk_o, ds_n = 1'b1;
  logic [31:0] hrdata, mbx_rdata;
  logic [3:0] br_oe, bg_in_n, bg_out_n, br_n = 4'hf;
  logic [7:0] vec_in;
  vsc_pkg::vsc_xfer_t xfer_cfg;
  int bad_count = 0, total_checks = 0, cyc = 0, l;

  vsc_syscon_irq u_vsc_syscon_irq (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp(), .irq, .inta_n, .serr_n, .nmi,
    .br_in_n(br_n), .bg_in_n, .bbsy_in_n(~bbsy_oe), .irq_in_n, .acfail_n(err_n[0]),
    .berr_in_n(err_n[1] & ~berr_oe), .sysfail_n(err_n[2]), .iack_in_n(ds_n), .ds_in_n(ds_n),
    .dtack_in_n, .vec_in, .br_oe, .bbsy_oe, .berr_oe, .iack_oe, .iack_lvl, .bg_out_n,
    .iackout_n, .sysclk_o, .sysclk_oe, .xfer_cfg, .mbx_acc, .mbx_wr, .mbx_idx,
    .mbx_wdata, .mbx_rdata);
  vsc_bp_model #(.DLY(7)) u_vsc_bp_model (.hclk, .hresetn, .br_oe, .iack_oe, .iack_lvl, .bg_in_n,
    .dtack_in_n, .vec_in);

  always #50 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  // fixed priority: highest requested level is granted
  function automatic logic [3:0] grant_n(input logic [3:0] r);
    grant_n = 4'hf;
    for (int i = 0; i < 4; i++) begin
      if (r[i]) grant_n = ~(4'h1 << i);
    end
  endfunction
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // poll status until bit b sets
  task automatic wst(input int b);
    repeat (400) begin
      ahb(0, `VSC_OFF_STAT, 0);
      if (rd[b] === 1'b1) break;
    end
    @(posedge hclk);
  endtask
  task automatic summarize();
    if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(0, `VSC_OFF_XFER, 0); chk("xfer_rst", `VSC_XFER_RST, rd);
    ahb(0, `VSC_OFF_CTRL, 0); chk("ctrl_rst", `VSC_CTRL_RST, rd);
    d = rnd() & 32'h1f;
    ahb(1, `VSC_OFF_XFER, d);
    ahb(0, `VSC_OFF_XFER, 0); chk("xfer", d, rd);
    chk("xfer_cfg", d, {27'h0, xfer_cfg[4:0]});
    ahb(0, 32'h80, 0); chk("unmapped", 0, rd);
    ahb(1, `VSC_OFF_IEN, 32'h1ffff);
    for (int i = 0; i < 4; i++) begin
      d = rnd();
      ahb(1, `VSC_OFF_MBX + 4 * i, d);
      mbx_acc <= 1'b1; mbx_wr <= 1'b0; mbx_idx <= i[1:0];
      @(posedge hclk); mbx_acc <= 1'b0;
      @(posedge hclk); chk("mbx_rdata", d, mbx_rdata);
      d = rnd();
      mbx_acc <= 1'b1; mbx_wr <= 1'b1; mbx_wdata <= d;
      @(posedge hclk); mbx_acc <= 1'b0;
      ahb(0, `VSC_OFF_MBX + 4 * i, 0); chk("mbx_host", d, rd);
      ahb(0, `VSC_OFF_STAT, 0); chk("mbx_st", 32'h1 << (7 + i), rd);
      chk("mbx_irq", 1, irq);
      ahb(1, `VSC_OFF_ICLR, 32'h1 << (7 + i));
      repeat (2) @(posedge hclk);
      ahb(0, `VSC_OFF_STAT, 0); chk("mbx_clr", 0, rd);
      chk("irq_clr", 0, irq);
    end
    for (int k = 0; k < 3; k++) begin
      m = rnd() & 32'h1;
      ahb(1, `VSC_OFF_IMAP, m << (12 + k));
      err_n[k] <= 1'b0;
      wst(12 + k); chk("err_st", 32'h1 << (12 + k), rd);
      chk("serr_n", m ^ 1, serr_n); chk("nmi", m, nmi); chk("inta_n", m, inta_n);
      err_n[k] <= 1'b1;
      ahb(1, `VSC_OFF_ICLR, 32'h1 << (12 + k));
    end
    for (int j = 0; j < 4; j++) begin
      l = (j == 0) ? 7 : (j == 1) ? 1 : int'(rnd() % 7) + 1;
      d = rnd() & 32'h3;
      m = rnd() & 32'h1;
      ahb(1, `VSC_OFF_CTRL, (d << 4) | (((rnd() & 32'h1) + 32'h1) << 6));
      ahb(1, `VSC_OFF_IMAP, m << (l - 1));
      ahb(1, `VSC_OFF_HEN, 32'h1 << l);
      irq_in_n <= 7'h00;
      repeat (40) begin
        @(posedge hclk);
        if (br_oe !== 4'h0) break;
      end
      chk("br_oe", 32'h1 << d, br_oe);
      wst(l - 1); chk("lvl_st", 32'h1 << (l - 1), rd);
      ahb(0, `VSC_OFF_VEC + 4 * (l - 1), 0); chk("vec", 32'ha0 | l, rd);
      chk("lvl_inta_n", m, inta_n); chk("lvl_nmi", m, nmi);
      irq_in_n <= 7'h7f;
      repeat (8) @(posedge hclk);
      chk("bbsy_rel", 0, bbsy_oe);
      ahb(1, `VSC_OFF_ICLR, 32'h1 << (l - 1));
    end
    ahb(1, `VSC_OFF_CTRL, 32'h5);
    @(posedge hclk); d[0] = sysclk_o;
    @(posedge hclk); chk("sysclk_oe", 1, sysclk_oe); chk("sysclk_o", !d[0], sysclk_o);
    m = (rnd() % 15) + 1;
    br_n <= ~m[3:0];
    wst(`VSC_ST_ARBTO); chk("arbto_st", 32'h1 << `VSC_ST_ARBTO, rd);
    chk("bg_out_n", grant_n(m[3:0]), bg_out_n);
    br_n <= 4'hf;
    ds_n <= 1'b0;
    wst(`VSC_ST_ACCTO); chk("accto_st", 1, rd >> `VSC_ST_ACCTO);
    chk("berr_oe", 1, berr_oe); chk("iackout_n", 0, iackout_n);
    ds_n <= 1'b1;
    summarize();
  end
endmodule
`default_nettype wire
